//--- verilog/euar_pkg.sv
// euar_pkg: register map, field positions, reset values and operand
// type codes shared by the execution-unit architecture register block.
// assumes a 32-bit APB register bus with 12-bit byte addresses.
package euar_pkg;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL0 = 12'h000;
    localparam logic [11:0] OFS_AIP = 12'h004;
    localparam logic [11:0] OFS_STATE0 = 12'h008;
    localparam logic [11:0] OFS_IP = 12'h00C;
    localparam logic [11:0] OFS_FLAG0 = 12'h010;
    localparam logic [11:0] OFS_FLAG1 = 12'h014;
    localparam logic [11:0] OFS_SIP = 12'h018;
    localparam logic [11:0] OFS_ADDR_BASE = 12'h040;
    localparam logic [11:0] OFS_PER_CHANNEL_INSTR_POINTER_BASE = 12'h080;
    localparam logic [11:0] OFS_ACC_BASE = 12'h100;

    // ==================================================================
    // control register zero fields
    localparam int CTRL0_SPF_BIT = 0;
    localparam int CTRL0_EXC_EN_BIT = 1;
    localparam int CTRL0_EXC_IND_BIT = 2;
    localparam int CTRL0_FLOW_MODE_BIT = 3;
    localparam int CTRL0_FP_MODE_LSB = 4;
    localparam int CTRL0_FP_MODE_W = 2;
    localparam logic [31:0] CTRL0_RST = 32'h0000_0001;

    // ==================================================================
    // state register zero fields
    localparam int STATE0_CHEN_LSB = 0;
    localparam int STATE0_TID_LSB = 16;
    localparam int STATE0_TID_W = 8;
    localparam int STATE0_PRIO_BIT = 24;
    localparam logic [31:0] STATE0_RST = 32'h0000_FFFF;

    // ==================================================================
    // sizes of architecture state
    localparam int NUM_ADDR_SUB = 16;
    localparam int ADDR_SUB_W = 16;
    localparam int FLAG_REG_W = 32;
    localparam int FLAG_SUB_W = 16;
    localparam int NUM_GEN_ACC = 2;
    localparam int GRF_BYTES_LOG2 = 5;

    // ==================================================================
    // operand element widths
    localparam int W_BYTE = 8;
    localparam int W_WORD = 16;
    localparam int W_DWORD = 32;
    localparam int W_QWORD = 64;
    localparam int NIB_W = 4;
    localparam int NIB_ELEMS = 8;
    localparam int VF_W = 8;
    localparam int VF_ELEMS = 4;

    typedef enum logic [3:0] {
        TY_SIGNED_BYTE = 4'h0,
        TY_UNSIGNED_OCTET = 4'h1,
        TY_SIGNED_WORD = 4'h2,
        TY_UNSIGNED_16BIT_INT = 4'h3,
        TY_SIGNED_DWORD = 4'h4,
        TY_UNSIGNED_32BIT_INT = 4'h5,
        TY_SIGNED_QWORD = 4'h6,
        TY_UNSIGNED_64BIT_INT = 4'h7,
        TY_UNSIGNED_NIBBLE_PACKED = 4'h8,
        TY_SIGNED_NIBBLE_PACKED = 4'h9,
        TY_PACKED_RESTRICTED_FLOAT_IMM = 4'hA,
        TY_HALF_PRECISION = 4'hB,
        TY_SINGLE_PRECISION = 4'hC,
        TY_DOUBLE_PRECISION = 4'hD
    } euar_dtype_t;

endpackage

//--- verilog/euar_opnd_unpack.sv
// euar_opnd_unpack: widens a source operand to 64 bits and splits the
// packed immediate vector forms into elements; purely combinational.
// assumes the caller registers the outputs.
`timescale 1ns/1ps
module euar_opnd_unpack import euar_pkg::*; (
    // operand in
    input wire euar_dtype_t opnd_type,
    input wire logic opnd_is_imm,
    input wire logic [63:0] opnd_raw,
    // unpacked out
    output logic [63:0] opnd_val,
    output logic [NIB_ELEMS-1:0][7:0] nib_elems,
    output logic [VF_ELEMS-1:0][VF_W-1:0] vf_elems,
    output logic opnd_illegal
);

    always_comb begin
        opnd_val = opnd_raw;
        opnd_illegal = 1'b0;
        for (int i = 0; i < NIB_ELEMS; i++) begin
            nib_elems[i] = {4'h0, opnd_raw[i*NIB_W +: NIB_W]};
        end
        for (int i = 0; i < VF_ELEMS; i++) begin
            vf_elems[i] = opnd_raw[i*VF_W +: VF_W];
        end
        case (opnd_type)
            TY_SIGNED_BYTE: opnd_val = {{56{opnd_raw[W_BYTE-1]}}, opnd_raw[W_BYTE-1:0]};
            TY_UNSIGNED_OCTET: opnd_val = {56'h0, opnd_raw[W_BYTE-1:0]};
            TY_SIGNED_WORD: opnd_val = {{48{opnd_raw[W_WORD-1]}}, opnd_raw[W_WORD-1:0]};
            TY_UNSIGNED_16BIT_INT: opnd_val = {48'h0, opnd_raw[W_WORD-1:0]};
            TY_SIGNED_DWORD: opnd_val = {{32{opnd_raw[W_DWORD-1]}}, opnd_raw[W_DWORD-1:0]};
            TY_UNSIGNED_32BIT_INT, TY_SINGLE_PRECISION: opnd_val = {32'h0, opnd_raw[W_DWORD-1:0]};
            TY_HALF_PRECISION: opnd_val = {48'h0, opnd_raw[W_WORD-1:0]};
            TY_UNSIGNED_NIBBLE_PACKED: begin
                opnd_val = {32'h0, opnd_raw[W_DWORD-1:0]};
                opnd_illegal = ~opnd_is_imm;
            end
            TY_SIGNED_NIBBLE_PACKED: begin
                opnd_val = {32'h0, opnd_raw[W_DWORD-1:0]};
                opnd_illegal = ~opnd_is_imm;
                for (int i = 0; i < NIB_ELEMS; i++) begin
                    nib_elems[i] = {{4{opnd_raw[i*NIB_W+3]}}, opnd_raw[i*NIB_W +: NIB_W]};
                end
            end
            TY_PACKED_RESTRICTED_FLOAT_IMM: begin
                opnd_val = {32'h0, opnd_raw[W_DWORD-1:0]};
                opnd_illegal = ~opnd_is_imm;
            end
            default: opnd_val = opnd_raw;
        endcase
    end

endmodule

//--- verilog/euar_chan_elig.sv
// euar_chan_elig: per-channel execution eligibility from the channel
// mask, the predicate flags and the per-channel instruction pointers.
// assumes all inputs are registered state of the same clock.
`timescale 1ns/1ps
module euar_chan_elig #(
    parameter int N_CH = 16
) (
    // control
    input wire logic single_program_flow,
    input wire logic [31:0] ip,
    input wire logic [N_CH-1:0][31:0] per_channel_instr_pointer,
    // masks
    input wire logic [N_CH-1:0] chan_mask,
    input wire logic pred_en,
    input wire logic pred_inv,
    input wire logic [N_CH-1:0] pred_flags,
    // result
    output logic [N_CH-1:0] elig
);

    always_comb begin
        for (int n = 0; n < N_CH; n++) begin
            elig[n] = chan_mask[n]
                & (~pred_en | (pred_flags[n] ^ pred_inv))
                & (single_program_flow | (per_channel_instr_pointer[n] == ip));
        end
    end

endmodule

//--- verilog/euar_top.sv
// euar_top: architecture register file of a vector execution unit:
// accumulators, address subregisters, control, flag, instruction
// pointer and state registers, plus operand widening.
// assumes APB software access and a same-clock decoder and datapath.
`timescale 1ns/1ps
module euar_top import euar_pkg::*; #(
    parameter int N_CH = 16,
    parameter int N_ACC = 10
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // result commit
    input wire logic wb_valid,
    input wire logic wb_dst_null,
    input wire logic [63:0] wb_data,
    input wire logic wb_acc_wr,
    input wire logic wb_acc_special,
    input wire logic [3:0] wb_acc_idx,
    output logic grf_wr_en,
    output logic [63:0] grf_wr_data,
    // flag update
    input wire logic flag_wr,
    input wire logic flag_reg_idx,
    input wire logic flag_sub_idx,
    input wire logic [15:0] flag_wr_data,
    // implicit accumulator source
    input wire logic [3:0] acc_rd_idx,
    input wire logic acc_rd_special,
    output logic [63:0] acc_rd_data,
    // indirect addressing
    input wire logic ind_req,
    input wire logic [3:0] ind_sub_idx,
    input wire logic [9:0] ind_imm,
    output logic ind_addr_valid,
    output logic [15:0] ind_byte_addr,
    output logic [15-GRF_BYTES_LOG2:0] ind_reg_num,
    output logic [GRF_BYTES_LOG2-1:0] ind_sub_reg,
    // source operand
    input wire logic opnd_req,
    input wire euar_dtype_t opnd_type,
    input wire logic opnd_is_imm,
    input wire logic opnd_is_null,
    input wire logic [63:0] opnd_raw,
    output logic opnd_valid,
    output logic [63:0] opnd_val,
    output logic [NIB_ELEMS-1:0][7:0] opnd_nib,
    output logic [VF_ELEMS-1:0][VF_W-1:0] opnd_vf,
    output logic opnd_illegal,
    // instruction flow
    input wire logic ip_wr,
    input wire logic [31:0] ip_wr_data,
    input wire logic per_channel_instr_pointer_wr,
    input wire logic [N_CH-1:0] per_channel_instr_pointer_wr_mask,
    input wire logic [31:0] per_channel_instr_pointer_wr_data,
    input wire logic exc_take,
    output logic exc_taken,
    output logic [31:0] ip_value,
    // predication and eligibility
    input wire logic pred_en,
    input wire logic pred_inv,
    input wire logic pred_flag_idx,
    output logic [N_CH-1:0] chan_elig
);

    // ==================================================================
    // state

    typedef struct packed {
        logic [31:0] ctrl0;
        logic [31:0] application_instr_pointer;
        logic [31:0] state0;
        logic [31:0] ip;
        logic [31:0] sip;
        logic [1:0][FLAG_REG_W-1:0] flags;
        logic [NUM_ADDR_SUB-1:0][ADDR_SUB_W-1:0] addr;
        logic [N_CH-1:0][31:0] per_channel_instr_pointer;
        logic [N_ACC-1:0][63:0] acc;
        logic [31:0] prdata;
        logic pslverr;
        logic grf_wr_en;
        logic [63:0] grf_wr_data;
        logic [63:0] acc_rd;
        logic ind_valid;
        logic [15:0] ind_addr;
        logic opnd_valid;
        logic [63:0] opnd_val;
        logic [NIB_ELEMS-1:0][7:0] nib;
        logic [VF_ELEMS-1:0][VF_W-1:0] vf;
        logic opnd_illegal;
        logic exc_taken;
        logic [N_CH-1:0] elig;
    } euar_state_t;

    euar_state_t s_q;
    euar_state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_sync_n;
    logic [63:0] unp_val;
    logic [NIB_ELEMS-1:0][7:0] unp_nib;
    logic [VF_ELEMS-1:0][VF_W-1:0] unp_vf;
    logic unp_illegal;
    logic [N_CH-1:0] elig_c;

    // ==================================================================
    // helpers

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // word index inside an array region, valid flag in the top bit
    function automatic logic [8:0] region_idx(input logic [11:0] a,
                                              input logic [11:0] base,
                                              input int count,
                                              input int stride_log2);
        logic [11:0] off;
        logic [7:0] idx;
        off = a - base;
        idx = off[stride_log2 +: 8];
        return {(a >= base) && ((int'(off) >> stride_log2) < count) && (off[1:0] == 2'b00), idx};
    endfunction

    // only acc0/acc1 unless the special-purpose path asks for more
    function automatic logic acc_ok(input logic [3:0] idx, input logic special);
        return (int'(idx) < N_ACC) && (special || (int'(idx) < NUM_GEN_ACC));
    endfunction

    // ==================================================================
    // reset release: async assert, two-flop release

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    // ==================================================================
    // submodules

    euar_opnd_unpack u_unpack (
        .opnd_type(opnd_type),
        .opnd_is_imm(opnd_is_imm),
        .opnd_raw(opnd_raw),
        .opnd_val(unp_val),
        .nib_elems(unp_nib),
        .vf_elems(unp_vf),
        .opnd_illegal(unp_illegal)
    );

    euar_chan_elig #(.N_CH(N_CH)) u_elig (
        .single_program_flow(s_q.ctrl0[CTRL0_SPF_BIT]),
        .ip(s_q.ip),
        .per_channel_instr_pointer(s_q.per_channel_instr_pointer),
        .chan_mask(s_q.state0[STATE0_CHEN_LSB +: N_CH]),
        .pred_en(pred_en),
        .pred_inv(pred_inv),
        .pred_flags(s_q.flags[pred_flag_idx][N_CH-1:0]),
        .elig(elig_c)
    );

    // ==================================================================
    // next state

    always_comb begin
        logic [8:0] ra;
        logic [8:0] rp;
        logic [8:0] rc;
        logic rd;
        logic wr;
        logic hit;
        logic [31:0] rv;
        logic [15:0] sum;
        logic [31:0] mw;
        mw = 32'h0;
        ra = region_idx(paddr, OFS_ADDR_BASE, NUM_ADDR_SUB, 2);
        rp = region_idx(paddr, OFS_PER_CHANNEL_INSTR_POINTER_BASE, N_CH, 2);
        rc = region_idx(paddr, OFS_ACC_BASE, N_ACC, 3);
        rd = psel & ~penable;
        wr = psel & penable & pwrite;
        hit = 1'b1;
        rv = 32'h0;
        sum = 16'h0;
        s_d = s_q;

        // register decode, shared by read and write
        if (paddr == OFS_CTRL0) begin
            rv = s_q.ctrl0;
        end else if (paddr == OFS_AIP) begin
            rv = s_q.application_instr_pointer;
        end else if (paddr == OFS_STATE0) begin
            rv = s_q.state0;
        end else if (paddr == OFS_IP) begin
            rv = s_q.ip;
        end else if (paddr == OFS_FLAG0) begin
            rv = s_q.flags[0];
        end else if (paddr == OFS_FLAG1) begin
            rv = s_q.flags[1];
        end else if (paddr == OFS_SIP) begin
            rv = s_q.sip;
        end else if (ra[8]) begin
            rv = {16'h0, s_q.addr[ra[3:0]]};
        end else if (rp[8]) begin
            rv = s_q.per_channel_instr_pointer[rp[7:0]];
        end else if (rc[8]) begin
            rv = paddr[2] ? s_q.acc[rc[7:0]][63:32] : s_q.acc[rc[7:0]][31:0];
        end else begin
            hit = 1'b0;
        end

        // read data and error are captured in setup, shown in access
        if (rd) begin
            s_d.prdata = hit ? rv : 32'h0;
            s_d.pslverr = ~hit;
        end

        if (wr && hit) begin
            if (paddr == OFS_CTRL0) begin
                s_d.ctrl0 = merge_strb(s_q.ctrl0, pwdata, pstrb);
            end else if (paddr == OFS_AIP) begin
                s_d.application_instr_pointer = merge_strb(s_q.application_instr_pointer, pwdata, pstrb);
            end else if (paddr == OFS_STATE0) begin
                s_d.state0 = merge_strb(s_q.state0, pwdata, pstrb);
            end else if (paddr == OFS_IP) begin
                s_d.ip = merge_strb(s_q.ip, pwdata, pstrb);
            end else if (paddr == OFS_FLAG0) begin
                s_d.flags[0] = merge_strb(s_q.flags[0], pwdata, pstrb);
            end else if (paddr == OFS_FLAG1) begin
                s_d.flags[1] = merge_strb(s_q.flags[1], pwdata, pstrb);
            end else if (paddr == OFS_SIP) begin
                s_d.sip = merge_strb(s_q.sip, pwdata, pstrb);
            end else if (ra[8]) begin
                mw = merge_strb({16'h0, s_q.addr[ra[3:0]]}, pwdata, pstrb);
                s_d.addr[ra[3:0]] = mw[15:0];
            end else if (rp[8]) begin
                s_d.per_channel_instr_pointer[rp[7:0]] = merge_strb(s_q.per_channel_instr_pointer[rp[7:0]], pwdata, pstrb);
            end else if (paddr[2]) begin
                s_d.acc[rc[7:0]][63:32] = merge_strb(s_q.acc[rc[7:0]][63:32],
                                                     pwdata, pstrb);
            end else begin
                s_d.acc[rc[7:0]][31:0] = merge_strb(s_q.acc[rc[7:0]][31:0],
                                                    pwdata, pstrb);
            end
        end

        // datapath updates land after software, so hardware wins a tie
        s_d.grf_wr_en = wb_valid & ~wb_dst_null;
        if (wb_valid && !wb_dst_null) begin
            s_d.grf_wr_data = wb_data;
        end
        if (wb_valid && wb_acc_wr && acc_ok(wb_acc_idx, wb_acc_special)) begin
            s_d.acc[wb_acc_idx] = wb_data;
        end
        if (flag_wr) begin
            s_d.flags[flag_reg_idx][flag_sub_idx*FLAG_SUB_W +: FLAG_SUB_W] =
                flag_wr_data;
        end

        // implicit accumulator source, zero when the index is not allowed
        s_d.acc_rd = acc_ok(acc_rd_idx, acc_rd_special) ? s_q.acc[acc_rd_idx]
                                                         : 64'h0;

        // indirect: subregister plus sign-extended offset, wraps at 16 bits
        s_d.ind_valid = ind_req;
        if (ind_req) begin
            sum = s_q.addr[ind_sub_idx] + {{6{ind_imm[9]}}, ind_imm};
            s_d.ind_addr = sum;
        end

        // source operand; a null source returns zero on opnd_val as its don't-care; opnd_nib and opnd_vf still unpack opnd_raw
        s_d.opnd_valid = opnd_req;
        if (opnd_req) begin
            s_d.opnd_val = opnd_is_null ? 64'h0 : unp_val;
            s_d.nib = unp_nib;
            s_d.vf = unp_vf;
            s_d.opnd_illegal = ~opnd_is_null & unp_illegal;
        end

        // instruction pointer; exception entry overrides a same-cycle write
        if (ip_wr) begin
            s_d.ip = ip_wr_data;
        end
        for (int n = 0; n < N_CH; n++) begin
            if (per_channel_instr_pointer_wr && per_channel_instr_pointer_wr_mask[n]) begin
                s_d.per_channel_instr_pointer[n] = per_channel_instr_pointer_wr_data;
            end
        end
        s_d.exc_taken = exc_take & s_q.ctrl0[CTRL0_EXC_EN_BIT];
        if (exc_take && s_q.ctrl0[CTRL0_EXC_EN_BIT]) begin
            s_d.application_instr_pointer = s_q.ip;
            s_d.ip = s_q.sip;
            s_d.ctrl0[CTRL0_EXC_IND_BIT] = 1'b1;
        end

        s_d.elig = elig_c;
    end

    // ==================================================================
    // state register

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_q <= '0;
            s_q.ctrl0 <= CTRL0_RST;
            s_q.state0 <= STATE0_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==================================================================
    // outputs

    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr & psel & penable;
    assign grf_wr_en = s_q.grf_wr_en;
    assign grf_wr_data = s_q.grf_wr_data;
    assign acc_rd_data = s_q.acc_rd;
    assign ind_addr_valid = s_q.ind_valid;
    assign ind_byte_addr = s_q.ind_addr;
    assign ind_reg_num = s_q.ind_addr[15:GRF_BYTES_LOG2];
    assign ind_sub_reg = s_q.ind_addr[GRF_BYTES_LOG2-1:0];
    assign opnd_valid = s_q.opnd_valid;
    assign opnd_val = s_q.opnd_val;
    assign opnd_nib = s_q.nib;
    assign opnd_vf = s_q.vf;
    assign opnd_illegal = s_q.opnd_illegal;
    assign exc_taken = s_q.exc_taken;
    assign ip_value = s_q.ip;
    assign chan_elig = s_q.elig;

endmodule

//--- verif/euar_chk.sv
// euar_chk: concurrent checks on the ports of euar_top.
// assumes binding into euar_top; one clock domain.
`timescale 1ns/1ps
module euar_chk import euar_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // commit
    input wire logic wb_valid,
    input wire logic wb_dst_null,
    input wire logic [63:0] wb_data,
    input wire logic grf_wr_en,
    input wire logic [63:0] grf_wr_data,
    // indirect
    input wire logic ind_req,
    input wire logic ind_addr_valid,
    input wire logic [15:0] ind_byte_addr,
    input wire logic [15-GRF_BYTES_LOG2:0] ind_reg_num,
    input wire logic [GRF_BYTES_LOG2-1:0] ind_sub_reg,
    // operand and exception
    input wire logic opnd_req,
    input wire euar_dtype_t opnd_type,
    input wire logic opnd_is_imm,
    input wire logic opnd_is_null,
    input wire logic opnd_valid,
    input wire logic opnd_illegal,
    input wire logic [NIB_ELEMS-1:0][7:0] opnd_nib,
    input wire logic exc_take,
    input wire logic exc_taken
);
    // ==================================================================
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_grf_commit: assert property (wb_valid && !wb_dst_null |=> grf_wr_en
        && grf_wr_data == $past(wb_data)) else $error("commit lost");
    a_null_drop: assert property (wb_valid && wb_dst_null |=> !grf_wr_en)
        else $error("null commit written");
    a_ind_answer: assert property (ind_req |=> ind_addr_valid) else $error("no address");
    a_ind_split: assert property (ind_addr_valid |->
        {ind_reg_num, ind_sub_reg} == ind_byte_addr) else $error("bad split");
    a_exc_cause: assert property (exc_taken |-> $past(exc_take)) else $error("stray exc");
    a_opnd_answer: assert property (opnd_req |=> opnd_valid) else $error("no operand");
    a_pack_imm: assert property (opnd_req && !opnd_is_imm && !opnd_is_null &&
        opnd_type inside {TY_UNSIGNED_NIBBLE_PACKED, TY_SIGNED_NIBBLE_PACKED,
        TY_PACKED_RESTRICTED_FLOAT_IMM} |=> opnd_illegal)
        else $error("packed non-immediate accepted");
    a_nib_sign: assert property (opnd_req && opnd_type == TY_SIGNED_NIBBLE_PACKED
        |=> opnd_nib[0][7:4] == {4{opnd_nib[0][3]}}) else $error("nibble not signed");
endmodule

//--- verif/euar_top_tb_top.sv
// euar_top_tb_top: self-checking bench for euar_top.
// assumes the APB slave answers with pready and registered datapath outputs.
`timescale 1ns/1ps
module euar_top_tb_top import euar_pkg::*; ();
    typedef struct {int k; logic [63:0] v;} euar_note_t;
    logic clock, rst_n, psel, penable, pwrite, wb_valid, wb_dst_null, wb_acc_wr, wb_acc_special;
    logic flag_wr, flag_reg_idx, flag_sub_idx, acc_rd_special, ind_req, opnd_req, opnd_is_imm;
    logic opnd_is_null, ip_wr, per_channel_instr_pointer_wr, exc_take, pred_en, pred_inv, pred_flag_idx, perr;
    logic pready, pslverr, grf_wr_en, ind_addr_valid, opnd_valid, opnd_illegal, exc_taken;
    logic [11:0] paddr;
    logic [31:0] pwdata, ip_wr_data, per_channel_instr_pointer_wr_data, prdata, ip_value, r, d, a, s;
    logic [3:0] pstrb, wb_acc_idx, acc_rd_idx, ind_sub_idx;
    logic [63:0] wb_data, opnd_raw, grf_wr_data, acc_rd_data, opnd_val, e, wd, prev;
    logic [15:0] flag_wr_data, per_channel_instr_pointer_wr_mask, ind_byte_addr, chan_elig;
    logic [9:0] ind_imm;
    logic [10:0] ind_reg_num;
    logic [4:0] ind_sub_reg;
    logic [7:0][7:0] opnd_nib;
    logic [3:0][7:0] opnd_vf;
    euar_dtype_t opnd_type;
    euar_note_t q[$];
    euar_note_t n;
    int num_errors = 0, checks = 0, cyc = 0, seed = 62, w;
    euar_top dut (.*);
    // ==================================================================
    // helpers
    task chk(string nm, logic [63:0] x, logic [63:0] y);
        checks++;
        if (x !== y) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, x, y);
        end
    endtask
    task apb(logic [11:0] ad, logic wr, logic [31:0] wdat);
        psel <= 1;
        paddr <= ad;
        pwrite <= wr;
        pwdata <= wdat;
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task print_verdict();
        if (q.size() != 0) num_errors++;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==================================================================
    // clock, timeout and result watcher
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    always @(negedge clock) begin
        if (grf_wr_en || ind_addr_valid || opnd_valid) begin
            n = q.pop_front();
            case (n.k)
                0: chk("grf", n.v, grf_wr_data);
                1: chk("ind", n.v, {48'h0, ind_byte_addr});
                2: chk("opnd", n.v, opnd_val);
                3: chk("nib", n.v, opnd_nib);
                5: chk("vf", n.v, opnd_vf);
                default: chk("illegal", n.v, {63'h0, opnd_illegal});
            endcase
        end
    end
    // ==================================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, wb_valid, wb_dst_null, wb_acc_wr, wb_acc_special, flag_wr} = '0;
        {flag_reg_idx, flag_sub_idx, acc_rd_special, ind_req, opnd_req, opnd_is_imm} = '0;
        {opnd_is_null, ip_wr, per_channel_instr_pointer_wr, exc_take, pred_en, pred_inv, pred_flag_idx} = '0;
        {paddr, pwdata, ip_wr_data, per_channel_instr_pointer_wr_data, wb_acc_idx, acc_rd_idx, ind_sub_idx} = '0;
        {wb_data, opnd_raw, flag_wr_data, per_channel_instr_pointer_wr_mask, ind_imm} = '0;
        opnd_type = TY_SIGNED_BYTE;
        pstrb = 4'hF;
        rst_n = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1;
        repeat (4) @(posedge clock);
        d = $random(seed);
        apb(OFS_IP, 1, d);
        apb(OFS_IP, 0, 32'h0);
        chk("ip", d, r);
        chk("ip_value", d, ip_value);
        apb(12'hFFC, 0, 32'h0);
        chk("unmapped", 64'h1_0000_0000, {31'h0, perr, r});
        // index 1, special index 5, then refused index 5 that must leave it alone
        for (int i = 0; i < 3; i++) begin
            wd = {$random(seed), $random(seed)};
            wb_valid <= 1;
            wb_dst_null <= i[0];
            wb_data <= wd;
            wb_acc_wr <= 1;
            wb_acc_idx <= (i == 0) ? 4'h1 : 4'h5;
            wb_acc_special <= (i == 1);
            if (!i[0]) q.push_back('{0, wd});
            @(posedge clock);
            wb_valid <= 0;
            acc_rd_idx <= (i == 0) ? 4'h1 : 4'h5;
            acc_rd_special <= (i != 0);
            @(posedge clock);
            @(negedge clock) chk("acc", (i == 2) ? prev : wd, acc_rd_data);
            prev = wd;
            @(posedge clock);
        end
        a = $random(seed);
        apb(OFS_ADDR_BASE + 12'h00C, 1, a);
        ind_imm <= 10'h3F0 | 10'($random(seed));
        @(posedge clock);
        ind_sub_idx <= 4'h3;
        ind_req <= 1;
        q.push_back('{1, {48'h0, 16'(a[15:0] + {{6{ind_imm[9]}}, ind_imm})}});
        @(posedge clock);
        ind_req <= 0;
        // back-to-back operands of every integer and packed type
        for (int t = 0; t < 11; t++) begin
            wd = {$random(seed), $random(seed)};
            opnd_type <= euar_dtype_t'(t);
            opnd_is_imm <= 1;
            opnd_raw <= wd;
            opnd_req <= 1;
            w = 8 << (t / 2);
            e = (w == 64) ? wd : wd & ((64'h1 << w) - 1);
            if (t < 8 && t % 2 == 0 && wd[w-1]) e = e | ~((64'h1 << w) - 1);
            if (t == 10) e = {32'h0, wd[31:0]};
            for (int k = 0; k < 8 && t > 7 && t < 10; k++) e[8*k+:8] = {{4{wd[4*k+3] & t[0]}}, wd[4*k+:4]};
            q.push_back('{(t > 9) ? 5 : (t > 7) ? 3 : 2, e});
            @(posedge clock);
        end
        opnd_type <= TY_UNSIGNED_NIBBLE_PACKED;
        opnd_is_imm <= 0;
        q.push_back('{4, 64'h1});
        @(posedge clock);
        opnd_req <= 0;
        s = $random(seed);
        apb(OFS_SIP, 1, s);
        apb(OFS_CTRL0, 1, 32'h2);
        exc_take <= 1;
        @(posedge clock);
        exc_take <= 0;
        @(negedge clock) chk("exc_taken", 1, exc_taken);
        @(posedge clock);
        apb(OFS_AIP, 0, 32'h0);
        chk("aip", d, r);
        apb(OFS_IP, 0, 32'h0);
        chk("ip_exc", s, r);
        apb(OFS_CTRL0, 0, 32'h0);
        chk("exc_ind", 1, r[CTRL0_EXC_IND_BIT]);
        a = $random(seed);
        for (int j = 0; j < 2; j++) begin
            per_channel_instr_pointer_wr <= 1;
            per_channel_instr_pointer_wr_mask <= j ? a[15:0] : 16'hFFFF;
            per_channel_instr_pointer_wr_data <= j ? s : s + 32'h4;
            @(posedge clock);
        end
        per_channel_instr_pointer_wr <= 0;
        repeat (3) @(posedge clock);
        @(negedge clock) chk("elig_per_channel_instr_pointer", a[15:0], chan_elig);
        apb(OFS_CTRL0, 1, 32'h1);
        repeat (3) @(posedge clock);
        @(negedge clock) chk("elig_spf", 16'hFFFF, chan_elig);
        flag_wr <= 1;
        flag_reg_idx <= 1;
        flag_wr_data <= a[31:16];
        @(posedge clock);
        flag_wr <= 0;
        pred_en <= 1;
        pred_flag_idx <= 1;
        repeat (3) @(posedge clock);
        @(negedge clock) chk("elig_pred", a[31:16], chan_elig);
        apb(OFS_FLAG1, 0, 32'h0);
        chk("flag1", a[31:16], r[15:0]);
        print_verdict();
    end
endmodule
bind euar_top euar_chk u_chk (.*);
